/* File: verilog/dcm_defs.vh */
`ifndef DCM_DEFS_VH
`define DCM_DEFS_VH
// ----------------------------------------
// register offsets (word index on the 8-bit address port)
// ----------------------------------------
`define DCM_REG_ENABLE     8'h00
`define DCM_REG_SRC_PLEN   8'h01
`define DCM_REG_DST_PLEN   8'h02
`define DCM_REG_SRC_PFX0   8'h04
`define DCM_REG_DST_PFX0   8'h08
`define DCM_REG_SPORT      8'h0c
`define DCM_REG_DPORT      8'h0d
`define DCM_REG_DSCP       8'h0e
`define DCM_REG_PREC       8'h0f
`define DCM_REG_TOS        8'h10
`define DCM_REG_PROTO      8'h11
`define DCM_REG_FLOW       8'h12
`define DCM_REG_STATUS     8'h13
`define DCM_REG_COUNT      8'h14
// ----------------------------------------
// enable register bit positions
// ----------------------------------------
`define DCM_EN_SRC_IP6  0
`define DCM_EN_DST_IP6  1
`define DCM_EN_SPORT    2
`define DCM_EN_DPORT    3
`define DCM_EN_DSCP     4
`define DCM_EN_PREC     5
`define DCM_EN_TOS      6
`define DCM_EN_PROTO    7
`define DCM_EN_FLOW     8
`define DCM_EN_WIDTH    9
// ----------------------------------------
// port register fields: [15:0] low, [31:16] high, [39:32] keyword
// ----------------------------------------
`define DCM_PORT_KW_SEL  32
// keyword register: bit 8 selects keyword, [7:0] keyword code
`define DCM_KW_SEL       8
// ----------------------------------------
// well-known protocol numbers
// ----------------------------------------
`define DCM_PROTO_TCP  8'h06
`define DCM_PROTO_UDP  8'h11
`endif

/* File: verilog/dcm_port_match.v */
// ----------------------------------------
// one transport port criterion: keyword, single port or range
// ----------------------------------------
module dcm_port_match (
  input wire [15:0] pkt_port,
  input wire [15:0] cfg_low,
  input wire [15:0] cfg_high,
  input wire cfg_kw_sel,
  input wire [15:0] cfg_kw_port,
  output wire hit
);
  // keyword overrides the explicit number and range
  wire [15:0] low = cfg_kw_sel ? cfg_kw_port : cfg_low;
  wire [15:0] high = cfg_kw_sel ? cfg_kw_port : cfg_high;
  // single port: high below low means compare against low only
  wire is_range = (high > low);
  // inclusive range or exact port
  assign hit = is_range ? ((pkt_port >= low) && (pkt_port <= high)) : (pkt_port == low);
endmodule // dcm_port_match

/* File: verilog/dcm_class_match.v */
// Behaviour
// - source ipv6 equals prefix over length
// - destination ipv6 equals prefix over length
// - source port equals port or in range
// - destination port equals port or in range
// - port keyword overrides number and range
// - dscp is upper six tos bits
// - dscp keyword overrides numeric value
// - precedence is upper three tos bits
// - tos criterion uses all eight bits
// - tos compares only masked bits
// - protocol equals value or keyword number
// - flow label twenty bits, equality only
//
// The register addresses and the strobed register port were left to the implementer.
`include "dcm_defs.vh"
module dcm_class_match (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire pkt_valid,
  input wire pkt_is_ip,
  input wire pkt_is_ipv6,
  input wire [127:0] pkt_src_ip6,
  input wire [127:0] pkt_dst_ip6,
  input wire [7:0] pkt_tos,
  input wire [7:0] pkt_proto,
  input wire [15:0] pkt_sport,
  input wire [15:0] pkt_dport,
  input wire [19:0] pkt_flow,
  output reg res_valid,
  output reg res_match,
  output reg [8:0] res_hits
);
  // ----------------------------------------
  // reset synchroniser
  // ----------------------------------------
  reg rst_meta_n;
  reg rst_n;
  // two-flop release of the async reset
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      // release reaches rst_n on the second edge
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  reg [8:0] cfg_en; // criterion enables
  reg [7:0] src_plen; // source prefix length 0..128
  reg [7:0] dst_plen; // destination prefix length
  reg [127:0] src_pfx; // source prefix, word 0 is bits 31:0
  reg [127:0] dst_pfx; // destination prefix
  reg [39:0] sport_cfg; // low, high, keyword select and code
  reg [39:0] dport_cfg;
  reg [8:0] dscp_cfg; // keyword select, code
  reg [2:0] prec_cfg; // precedence value
  reg [15:0] tos_cfg; // [15:8] mask, [7:0] value
  reg [8:0] proto_cfg; // keyword select, value or keyword code
  reg [19:0] flow_cfg; // flow label
  reg [31:0] match_count; // matched packets
  wire [1:0] wsel = reg_addr[1:0];
  // combined verdict, driven in the criteria section
  wire class_match;

  // register writes; counter counts matches
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // every criterion disabled, all fields cleared
      cfg_en <= 9'h000;
      src_plen <= 8'h00;
      dst_plen <= 8'h00;
      src_pfx <= 128'h0;
      dst_pfx <= 128'h0;
      sport_cfg <= 40'h0;
      dport_cfg <= 40'h0;
      dscp_cfg <= 9'h000;
      prec_cfg <= 3'h0;
      tos_cfg <= 16'h0000;
      proto_cfg <= 9'h000;
      flow_cfg <= 20'h00000;
      match_count <= 32'h0;
    end else begin
      // software writes; unmapped indexes are ignored
      if (reg_wr) begin
        if (reg_addr == `DCM_REG_ENABLE) begin
          cfg_en <= reg_wdata[8:0];
        end else if (reg_addr == `DCM_REG_SRC_PLEN) begin
          src_plen <= reg_wdata[7:0];
        end else if (reg_addr == `DCM_REG_DST_PLEN) begin
          dst_plen <= reg_wdata[7:0];
        end else if ({reg_addr[7:2], 2'h0} == `DCM_REG_SRC_PFX0) begin
          // four prefix words, wsel picks the slice
          src_pfx[wsel*32 +: 32] <= reg_wdata;
        end else if ({reg_addr[7:2], 2'h0} == `DCM_REG_DST_PFX0) begin
          dst_pfx[wsel*32 +: 32] <= reg_wdata;
        end else if (reg_addr == `DCM_REG_SPORT) begin
          sport_cfg[31:0] <= reg_wdata;
        end else if (reg_addr == `DCM_REG_DPORT) begin
          dport_cfg[31:0] <= reg_wdata;
        end else if (reg_addr == `DCM_REG_DSCP) begin
          dscp_cfg <= reg_wdata[8:0];
        end else if (reg_addr == `DCM_REG_PREC) begin
          prec_cfg <= reg_wdata[2:0];
        end else if (reg_addr == `DCM_REG_TOS) begin
          tos_cfg <= reg_wdata[15:0];
        end else if (reg_addr == `DCM_REG_PROTO) begin
          proto_cfg <= reg_wdata[8:0];
        end else if (reg_addr == `DCM_REG_STATUS) begin
          // status write: keyword bytes for the two port criteria
          sport_cfg[39:32] <= reg_wdata[7:0];
          dport_cfg[39:32] <= reg_wdata[15:8];
        end else if (reg_addr == `DCM_REG_COUNT) begin
          match_count <= 32'h0;
        end else if (reg_addr == `DCM_REG_FLOW) begin
          flow_cfg <= reg_wdata[19:0];
        end
      end
      // a clear written in the same cycle beats the increment
      if (pkt_valid && class_match && !(reg_wr && reg_addr == `DCM_REG_COUNT)) begin
        match_count <= match_count + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // keyword tables
  // ----------------------------------------
  // port keyword code: 0 none, bit 7 select, low bits pick a well-known port
  function [15:0] kw_port;
    input [6:0] code;
    begin
      case (code)
        7'h01: kw_port = 16'h0014; // ftp-data
        7'h02: kw_port = 16'h0015; // ftp
        7'h03: kw_port = 16'h0017; // telnet
        7'h04: kw_port = 16'h0019; // smtp
        7'h05: kw_port = 16'h0035; // domain
        7'h06: kw_port = 16'h0045; // tftp
        7'h07: kw_port = 16'h0050; // http
        7'h08: kw_port = 16'h00a1; // snmp
        7'h09: kw_port = 16'h0043; // bootp server
        7'h0a: kw_port = 16'h0044; // bootp client
        7'h0b: kw_port = 16'h0208; // rip
        default: kw_port = 16'h0000;
      endcase
    end
  endfunction

  // dscp keyword code: 0..11 af classes, 12 ef, 13..20 cs0..cs7
  function [5:0] kw_dscp;
    input [7:0] code;
    begin
      if (code < 8'h0c) begin
        // afxy is 8x + 2y; the sum lets y reach four without wrapping
        kw_dscp = {1'b0, code[3:2] + 2'h1, 3'h0} + {2'h0, {1'b0, code[1:0]} + 3'h1, 1'b0};
      end else if (code == 8'h0c) begin
        // expedited forwarding
        kw_dscp = 6'h2e;
      end else if (code < 8'h15) begin
        // class selectors, codes 13..20 give cs0..cs7
        kw_dscp = {code[2:0] - 3'h5, 3'h0};
      end else begin
        kw_dscp = 6'h00;
      end
    end
  endfunction

  // protocol keyword code: small set of common protocol numbers
  function [7:0] kw_proto;
    input [7:0] code;
    begin
      case (code)
        8'h01: kw_proto = 8'h01; // icmp
        8'h02: kw_proto = 8'h02; // igmp
        8'h03: kw_proto = 8'h04; // ip in ip
        8'h04: kw_proto = `DCM_PROTO_TCP;
        8'h05: kw_proto = `DCM_PROTO_UDP;
        8'h06: kw_proto = 8'h3a; // icmpv6
        default: kw_proto = 8'hff;
      endcase
    end
  endfunction

  // ----------------------------------------
  // criteria
  // ----------------------------------------
  // prefix masks: ones in the top plen bits
  wire [127:0] src_mask = (src_plen >= 8'h80) ? {128{1'b1}} : ~({128{1'b1}} >> src_plen);
  wire [127:0] dst_mask = (dst_plen >= 8'h80) ? {128{1'b1}} : ~({128{1'b1}} >> dst_plen);

  // ports exist only in tcp and udp headers
  wire is_l4 = pkt_is_ip && (pkt_proto == `DCM_PROTO_TCP || pkt_proto == `DCM_PROTO_UDP);
  // ipv6 prefixes; a packet without an ipv6 header misses
  wire hit_src = pkt_is_ipv6 && (((pkt_src_ip6 ^ src_pfx) & src_mask) == 128'h0);
  wire hit_dst = pkt_is_ipv6 && (((pkt_dst_ip6 ^ dst_pfx) & dst_mask) == 128'h0);

  // one matcher per port direction
  wire sport_raw;
  wire dport_raw;
  dcm_port_match u_sport (
    .pkt_port(pkt_sport),
    .cfg_low(sport_cfg[15:0]),
    .cfg_high(sport_cfg[31:16]),
    .cfg_kw_sel(sport_cfg[39]),
    .cfg_kw_port(kw_port(sport_cfg[38:32])),
    .hit(sport_raw)
  );
  dcm_port_match u_dport (
    .pkt_port(pkt_dport),
    .cfg_low(dport_cfg[15:0]),
    .cfg_high(dport_cfg[31:16]),
    .cfg_kw_sel(dport_cfg[39]),
    .cfg_kw_port(kw_port(dport_cfg[38:32])),
    .hit(dport_raw)
  );
  // a port hit also needs a tcp or udp header
  wire hit_sport = is_l4 && sport_raw;
  wire hit_dport = is_l4 && dport_raw;

  // service octet criteria
  // keyword picks the code point, numeric value ignored then
  wire [5:0] dscp_want = dscp_cfg[`DCM_KW_SEL] ? kw_dscp(dscp_cfg[7:0]) : dscp_cfg[5:0];
  wire hit_dscp = pkt_is_ip && (pkt_tos[7:2] == dscp_want);
  wire hit_prec = pkt_is_ip && (pkt_tos[7:5] == prec_cfg);
  wire hit_tos = pkt_is_ip && (((pkt_tos ^ tos_cfg[7:0]) & tos_cfg[15:8]) == 8'h00);
  // protocol keyword replaces the numeric value
  wire [7:0] proto_want = proto_cfg[`DCM_KW_SEL] ? kw_proto(proto_cfg[7:0]) : proto_cfg[7:0];
  wire hit_proto = pkt_is_ip && (pkt_proto == proto_want);
  // flow label exists only in ipv6 headers
  wire hit_flow = pkt_is_ipv6 && (pkt_flow == flow_cfg);
  // hit vector in enable bit order
  wire [8:0] hits = {hit_flow, hit_proto, hit_tos, hit_prec, hit_dscp, hit_dport, hit_sport, hit_dst, hit_src};
  // disabled criteria count as hits
  assign class_match = &(hits | ~cfg_en);

  // ----------------------------------------
  // result and read data
  // ----------------------------------------
  // one result per packet, one cycle later
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_match <= 1'b0;
      res_hits <= 9'h000;
    end else begin
      // each result stands for one cycle only
      res_valid <= pkt_valid;
      res_match <= pkt_valid & class_match;
      res_hits <= pkt_valid ? hits : 9'h000;
    end
  end

  // registered read, zero for unmapped addresses
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (!reg_rd) begin
      // no read strobe: the bus rests at zero
      reg_rdata <= 32'h0;
    end else if (reg_addr == `DCM_REG_ENABLE) begin
      reg_rdata <= {23'h0, cfg_en};
    end else if (reg_addr == `DCM_REG_SRC_PLEN) begin
      reg_rdata <= {24'h0, src_plen};
    end else if (reg_addr == `DCM_REG_DST_PLEN) begin
      reg_rdata <= {24'h0, dst_plen};
    end else if ({reg_addr[7:2], 2'h0} == `DCM_REG_SRC_PFX0) begin
      // same word order as the writes
      reg_rdata <= src_pfx[wsel*32 +: 32];
    end else if ({reg_addr[7:2], 2'h0} == `DCM_REG_DST_PFX0) begin
      reg_rdata <= dst_pfx[wsel*32 +: 32];
    end else if (reg_addr == `DCM_REG_SPORT) begin
      reg_rdata <= sport_cfg[31:0];
    end else if (reg_addr == `DCM_REG_DPORT) begin
      reg_rdata <= dport_cfg[31:0];
    end else if (reg_addr == `DCM_REG_DSCP) begin
      reg_rdata <= {23'h0, dscp_cfg};
    end else if (reg_addr == `DCM_REG_PREC) begin
      reg_rdata <= {29'h0, prec_cfg};
    end else if (reg_addr == `DCM_REG_TOS) begin
      reg_rdata <= {16'h0, tos_cfg};
    end else if (reg_addr == `DCM_REG_PROTO) begin
      reg_rdata <= {23'h0, proto_cfg};
    end else if (reg_addr == `DCM_REG_FLOW) begin
      reg_rdata <= {12'h0, flow_cfg};
    end else if (reg_addr == `DCM_REG_STATUS) begin
      // keyword bytes and the result registers, zero outside a result cycle
      reg_rdata <= {5'h0, res_match, res_hits, 1'b0, dport_cfg[39:32], sport_cfg[39:32]};
    end else if (reg_addr == `DCM_REG_COUNT) begin
      reg_rdata <= match_count;
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule // dcm_class_match

/* File: tb/dcm_pkt_src.sv */
// upstream header parser stand-in: one packet per send, fields scrambled between packets
module dcm_pkt_src (
  input wire sys_clk,
  output logic pkt_valid,
  output wire pkt_is_ip,
  output wire pkt_is_ipv6,
  output wire [127:0] pkt_src_ip6,
  output wire [127:0] pkt_dst_ip6,
  output wire [7:0] pkt_tos,
  output wire [7:0] pkt_proto,
  output wire [15:0] pkt_sport,
  output wire [15:0] pkt_dport,
  output wire [19:0] pkt_flow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ip, v6;  // header kind of the next packet
  logic [127:0] sa, da;  // addresses of the next packet
  logic [7:0] tos, pr;  // service octet and protocol
  logic [15:0] sp, dp;  // transport ports
  logic [19:0] fl;  // flow label
  logic [325:0] drv = '0;  // all fields as driven
  assign {pkt_is_ip, pkt_is_ipv6, pkt_src_ip6, pkt_dst_ip6, pkt_tos, pkt_proto, pkt_sport, pkt_dport, pkt_flow} = drv;
  initial pkt_valid = 1'b0;
  // one-cycle packet, then the lines show the inverse so stale values never match
  task send();
    @(posedge sys_clk);
    pkt_valid <= 1'b1;
    drv <= {ip, v6, sa, da, tos, pr, sp, dp, fl};
    @(posedge sys_clk);
    pkt_valid <= 1'b0;
    drv <= ~{ip, v6, sa, da, tos, pr, sp, dp, fl};
  endtask
endmodule  // dcm_pkt_src

/* File: tb/dcm_class_match_sva.sv */
module dcm_chk (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire pkt_valid,
  input wire pkt_is_ip,
  input wire pkt_is_ipv6,
  input wire [7:0] pkt_tos,
  input wire [19:0] pkt_flow,
  input wire res_valid,
  input wire res_match,
  input wire [8:0] res_hits
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] en;  // shadow of the enable word
  logic [15:0] tos;  // shadow of mask and value
  logic [19:0] flow;  // shadow of the flow label
  // follow register writes so results can be predicted
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      en <= 9'h000;
      tos <= 16'h0000;
      flow <= 20'h00000;
    end else if (reg_wr) begin
      if (reg_addr == 8'h00) en <= reg_wdata[8:0];
      if (reg_addr == 8'h10) tos <= reg_wdata[15:0];
      if (reg_addr == 8'h12) flow <= reg_wdata[19:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence pkt_take;
    pkt_valid ##1 res_valid;
  endsequence
  res_latency_a: assert property (pkt_valid |-> pkt_take) else $error("result not one cycle after packet");
  res_pulse_a: assert property (!pkt_valid |=> !res_valid) else $error("result without packet");
  match_all_a: assert property (res_valid |-> res_match == &(res_hits | ~en))
    else $error("match differs from enabled hits");
  v6_absent_a: assert property (pkt_valid && !pkt_is_ipv6 && (en[0] || en[1] || en[8]) |=> !res_match)
    else $error("ipv6 criterion hit on other packet");
  ip_absent_a: assert property (pkt_valid && !pkt_is_ip && (|en[7:4]) |=> !res_match)
    else $error("ip criterion hit on non ip packet");
  flow_equal_a: assert property (pkt_valid && pkt_is_ipv6 && en[8] |=> res_hits[8] == ($past(pkt_flow) == flow))
    else $error("flow label hit wrong");
  tos_masked_a: assert property (pkt_valid && pkt_is_ip && en[6] |=>
    res_hits[6] == ((($past(pkt_tos) ^ tos[7:0]) & tos[15:8]) == 8'h00)) else $error("tos hit wrong");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read");
  rd_unmapped_a: assert property (reg_rd && reg_addr > 8'h14 |=> reg_rdata == 32'h0) else $error("unmapped read");
endmodule  // dcm_chk
bind dcm_class_match dcm_chk dcm_chk_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
  .pkt_is_ip(pkt_is_ip), .pkt_is_ipv6(pkt_is_ipv6), .pkt_tos(pkt_tos), .pkt_flow(pkt_flow),
  .res_valid(res_valid), .res_match(res_match), .res_hits(res_hits));

/* File: tb/dcm_class_match_test.sv */
module dcm_class_match_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [127:0] A = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;  // reference address
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [31:0] reg_rdata;
  wire pkt_valid, pkt_is_ip, pkt_is_ipv6, res_valid, res_match;
  wire [127:0] pkt_src_ip6, pkt_dst_ip6;
  wire [7:0] pkt_tos, pkt_proto;
  wire [15:0] pkt_sport, pkt_dport;
  wire [19:0] pkt_flow;
  wire [8:0] res_hits;
  logic [15:0] kwp [12] = '{16'd0, 16'd20, 16'd21, 16'd23, 16'd25, 16'd53, 16'd69, 16'd80, 16'd161, 16'd67,
    16'd68, 16'd520};  // port per keyword code
  logic [7:0] pn [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h11, 8'h3a};  // protocol per keyword code
  logic [5:0] d;  // expected code point
  int n_errors = 0;
  int total_checks = 0;
  always #50 sys_clk = ~sys_clk;
  dcm_class_match dcm_class_match_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_is_ip(pkt_is_ip),
    .pkt_is_ipv6(pkt_is_ipv6), .pkt_src_ip6(pkt_src_ip6), .pkt_dst_ip6(pkt_dst_ip6), .pkt_tos(pkt_tos),
    .pkt_proto(pkt_proto), .pkt_sport(pkt_sport), .pkt_dport(pkt_dport), .pkt_flow(pkt_flow), .res_valid(res_valid),
    .res_match(res_match), .res_hits(res_hits));
  dcm_pkt_src dcm_pkt_src_i (.sys_clk(sys_clk), .pkt_valid(pkt_valid), .pkt_is_ip(pkt_is_ip), .pkt_is_ipv6(pkt_is_ipv6),
    .pkt_src_ip6(pkt_src_ip6), .pkt_dst_ip6(pkt_dst_ip6), .pkt_tos(pkt_tos), .pkt_proto(pkt_proto),
    .pkt_sport(pkt_sport), .pkt_dport(pkt_dport), .pkt_flow(pkt_flow));
  task end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk_rd(input logic [31:0] e);
    total_checks++;
    if (reg_rdata !== e) begin
      n_errors++;
      $display("ERROR reg_rdata expected %h seen %h", e, reg_rdata);
    end
  endtask
  task chk_res(input logic e);
    total_checks++;
    if (res_valid !== 1'b1 || res_match !== e) begin
      n_errors++;
      $display("ERROR res_match expected %b seen %b valid %b", e, res_match, res_valid);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_rd(e);
  endtask
  // send the prepared packet and judge the result cycle
  task pk(input logic e);
    dcm_pkt_src_i.send();
    #1 chk_res(e);
  endtask
  task base();
    dcm_pkt_src_i.ip = 1'b1;
    dcm_pkt_src_i.v6 = 1'b1;
    dcm_pkt_src_i.sa = A;
    dcm_pkt_src_i.da = A;
    dcm_pkt_src_i.pr = 8'h06;
    dcm_pkt_src_i.fl = 20'h00000;
    dcm_pkt_src_i.tos = 8'h00;
    dcm_pkt_src_i.sp = 16'h0000;
    dcm_pkt_src_i.dp = 16'h0000;
  endtask
  task flp(input int n);
    dcm_pkt_src_i.sa[n] = ~dcm_pkt_src_i.sa[n];
    dcm_pkt_src_i.da[n] = ~dcm_pkt_src_i.da[n];
  endtask
  task prt(input logic [15:0] v, input logic e);
    dcm_pkt_src_i.sp = v;
    dcm_pkt_src_i.dp = v;
    pk(e);
  endtask
  task ts(input logic [7:0] t, input logic e);
    dcm_pkt_src_i.tos = t;
    pk(e);
  endtask
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end
  initial begin
    base();
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wr(8'h03, 32'hffffffff);
    rd(8'h03, 32'h0);
    rd(8'hff, 32'h0);
    wr(8'h00, 32'h0);
    ts(8'h00, 1'b1);
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 32'h1 << k);
      wr(8'(1 + k), 32'd48);
      for (int i = 0; i < 4; i++) wr(8'(4 + 4 * k + i), A[32 * i +: 32]);
      pk(1'b1);
      flp(79);
      pk(1'b1);
      flp(80);
      pk(1'b0);
      base();
      dcm_pkt_src_i.v6 = 1'b0;
      pk(1'b0);
      base();
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 32'h4 << k);
      wr(8'h13, 32'h0);
      wr(8'(12 + k), {16'd2000, 16'd1000});
      prt(16'd1000, 1'b1);
      prt(16'd2000, 1'b1);
      prt(16'd2001, 1'b0);
      prt(16'd999, 1'b0);
      wr(8'(12 + k), {16'd0, 16'd80});
      prt(16'd81, 1'b0);
      for (int c = 1; c < 12; c++) begin
        wr(8'h13, (32'h80 | c) << (8 * k));
        prt(kwp[c], 1'b1);
        prt(16'd80, c == 7);
      end
      dcm_pkt_src_i.pr = 8'h11;
      prt(16'd520, 1'b1);
      dcm_pkt_src_i.pr = 8'h01;
      prt(16'd520, 1'b0);
      base();
    end
    wr(8'h00, 32'h10);
    wr(8'h0e, 32'h2e);
    ts(8'hbb, 1'b1);
    ts(8'hb4, 1'b0);
    for (int c = 0; c < 21; c++) begin
      wr(8'h0e, 32'h100 | c);
      d = (c < 12) ? 6'(8 * (c / 4 + 1) + 2 * (c % 4 + 1)) : (c == 12) ? 6'd46 : 6'(8 * (c - 13));
      ts({d, 2'b01}, 1'b1);
      ts({d ^ 6'h01, 2'b00}, 1'b0);
    end
    wr(8'h00, 32'h20);
    wr(8'h0f, 32'h5);
    ts(8'hbf, 1'b1);
    ts(8'hc0, 1'b0);
    wr(8'h00, 32'h40);
    wr(8'h10, 32'hf0a5);
    ts(8'haf, 1'b1);
    ts(8'hb5, 1'b0);
    ts(8'h25, 1'b0);
    wr(8'h00, 32'h80);
    wr(8'h11, 32'h2f);
    dcm_pkt_src_i.pr = 8'h2f;
    pk(1'b1);
    for (int c = 1; c < 7; c++) begin
      wr(8'h11, 32'h100 | c);
      dcm_pkt_src_i.pr = pn[c];
      pk(1'b1);
      dcm_pkt_src_i.pr = 8'h2f;
      pk(1'b0);
    end
    dcm_pkt_src_i.ip = 1'b0;
    pk(1'b0);
    base();
    wr(8'h00, 32'h100);
    wr(8'h12, 32'h12345);
    wr(8'h14, 32'h0);
    dcm_pkt_src_i.fl = 20'h12345;
    pk(1'b1);
    dcm_pkt_src_i.fl = 20'h92345;
    pk(1'b0);
    wr(8'h00, 32'h140);
    dcm_pkt_src_i.fl = 20'h12345;
    ts(8'h00, 1'b0);
    rd(8'h14, 32'h1);
    rd(8'h13, 32'h8b00);
    end_of_test();
  end
endmodule  // dcm_class_match_test
